// *** logic/bct_unit.sv ***
/*
 * bit column transpose datapath: gather one bit column of sixteen words into a word,
 * or scatter a word into one bit column of sixteen words, keeping the other bits.
 * assumes the sequencer issues one operation at a time and waits for o_done;
 * words are loaded and read back through the word port (index 0 is the first word).
 * limitation: starts, word writes and word reads that arrive while busy are dropped
 * without any indication, so the sequencer must pace itself on o_done.
 */
`timescale 1ns/1ps
`default_nettype none
`include "bct_regs.svh"

// Notes on behaviour
// - both operations raise the fault flag for a bit number above 15 and clear it otherwise.
// - gather puts bit N of word m into bit m of the result word.
// - after gather the zero flag is set exactly when the result word is zero.
// - scatter writes bit m of the source word into bit N of word m.
// - scatter keeps every bit other than bit N of each word.
// - after scatter the zero flag is set when bit N is zero in all sixteen words.
module bct_unit
    import bct_pkg::*;
#(
    parameter int WIDTH = `BCT_WORD_W,
    parameter int DEPTH = `BCT_NUM_WORDS,
    parameter int AW    = `BCT_IDX_W
) (
    input  wire logic             i_ref_clk,
    input  wire logic             i_rstn,
    input  wire logic             i_start,
    input  wire bct_req_t         i_req,
    input  wire logic             i_wr,
    input  wire logic             i_rd,
    input  wire logic [AW-1:0]    i_word_idx,
    input  wire logic [WIDTH-1:0] i_word_wdata,
    output logic      [WIDTH-1:0] o_word_rdata,
    output logic                  o_word_rvalid,
    output logic                  o_busy,
    output logic                  o_done,
    output bct_flags_t            o_flags,
    output logic      [WIDTH-1:0] o_result
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    // one-hot; reset and every transition load one of the four codes, so the case needs no default
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_READ = 4'h2,
        ST_STEP = 4'h4,
        ST_DONE = 4'h8
    } bct_state_t;

    bct_state_t       state, next_state;
    bct_op_t          op, next_op;
    logic [AW-1:0]    bit_n, next_bit_n;
    logic [WIDTH-1:0] src, next_src;
    logic [AW-1:0]    idx, next_idx;
    logic [WIDTH-1:0] acc, next_acc;
    logic             last_rd, next_last_rd;
    logic             busy, next_busy;
    logic             done, next_done;
    bct_flags_t       flags, next_flags;
    logic [WIDTH-1:0] result, next_result;
    logic             rvalid, next_rvalid;

    // ----------------------------------------------------------------
    // memory port mux
    // ----------------------------------------------------------------
    logic             mem_we;
    logic [AW-1:0]    mem_waddr;
    logic [WIDTH-1:0] mem_wdata;
    logic [AW-1:0]    mem_raddr;
    logic [WIDTH-1:0] mem_rdata;
    logic [WIDTH-1:0] merged;
    logic [AW-1:0]    idx_inc;

    bct_word_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem (
        .i_ref_clk (i_ref_clk),
        .i_we      (mem_we),
        .i_waddr   (mem_waddr),
        .i_wdata   (mem_wdata),
        .i_raddr   (mem_raddr),
        .o_rdata   (mem_rdata)
    );

    // ----------------------------------------------------------------
    // per-bit merge for scatter
    // ----------------------------------------------------------------
    // the word read back is rewritten whole, so every other column must pass through
    genvar gb;
    generate
        for (gb = 0; gb < WIDTH; gb++) begin : g_merge
            // only column bit_n takes the source bit of this word
            assign merged[gb] = (gb == int'(bit_n)) ? src[idx] : mem_rdata[gb];
        end
    endgenerate

    // the wrap from the last word back to 0 is harmless: that step leaves for ST_DONE
    assign idx_inc = AW'(idx + 1'b1);

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        next_state   = state;
        next_op      = op;
        next_bit_n   = bit_n;
        next_src     = src;
        next_idx     = idx;
        next_acc     = acc;
        next_last_rd = 1'b0;
        next_busy    = busy;
        next_done    = 1'b0;
        next_flags   = flags;
        next_result  = result;
        next_rvalid  = 1'b0;
        // the memory port defaults to the word port, so idle traffic needs no extra state
        mem_we       = 1'b0;
        mem_waddr    = i_word_idx;
        mem_wdata    = i_word_wdata;
        mem_raddr    = i_word_idx;
        unique case (state)
            ST_IDLE: begin
                if (i_start) begin
                    next_op    = i_req.op;
                    next_bit_n = i_req.bit_num[AW-1:0];
                    next_src   = i_req.src_word;
                    next_idx   = `BCT_ZERO_IDX;
                    next_acc   = `BCT_ZERO_WORD;
                    next_busy  = 1'b1;
                    if (i_req.bit_num > `BCT_BITNUM_MAX) begin
                        // no word is touched on a bad column number
                        next_flags.fault_flag = 1'b1;
                        next_state = ST_DONE;
                    end else begin
                        next_flags.fault_flag = 1'b0;
                        mem_raddr  = `BCT_ZERO_IDX;
                        next_state = ST_READ;
                    end
                end else begin
                    // the word port is only served while idle and not starting
                    mem_we       = i_wr;
                    next_last_rd = i_rd;
                    next_rvalid  = last_rd;
                end
            end
            ST_READ: begin
                // one cycle for the registered read of word idx
                mem_raddr  = idx;
                next_state = ST_STEP;
            end
            ST_STEP: begin
                // merge and write back: one memory port is traded for two cycles a word
                if (op == BCT_OP_SCATTER) begin
                    mem_we    = 1'b1;
                    mem_waddr = idx;
                    mem_wdata = merged;
                    next_acc[idx] = src[idx];
                end else begin
                    next_acc[idx] = mem_rdata[bit_n];
                end
                next_idx   = idx_inc;
                mem_raddr  = idx_inc;
                next_state = (idx == `BCT_LAST_IDX) ? ST_DONE : ST_READ;
            end
            ST_DONE: begin
                next_busy  = 1'b0;
                next_done  = 1'b1;
                next_state = ST_IDLE;
                // on a fault the zero flag and the result keep their last good values
                if (!flags.fault_flag) begin
                    next_result = (op == BCT_OP_GATHER) ? acc : result;
                    // acc now holds column N (equal to src after scatter), so zero means every column bit is zero
                    next_flags.zero_flag = (acc == `BCT_ZERO_WORD);
                end
            end
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // word memory is not reset; control state, operands, accumulator, flags and result are
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state   <= ST_IDLE;
            op      <= BCT_OP_GATHER;
            bit_n   <= `BCT_ZERO_IDX;
            src     <= `BCT_ZERO_WORD;
            idx     <= `BCT_ZERO_IDX;
            acc     <= `BCT_ZERO_WORD;
            last_rd <= 1'b0;
            busy    <= 1'b0;
            done    <= 1'b0;
            flags   <= '0;
            result  <= `BCT_ZERO_WORD;
            rvalid  <= 1'b0;
        end else begin
            state   <= next_state;
            op      <= next_op;
            bit_n   <= next_bit_n;
            src     <= next_src;
            idx     <= next_idx;
            acc     <= next_acc;
            last_rd <= next_last_rd;
            busy    <= next_busy;
            done    <= next_done;
            flags   <= next_flags;
            result  <= next_result;
            rvalid  <= next_rvalid;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // memory read data is itself a register
    assign o_word_rdata  = mem_rdata;
    assign o_word_rvalid = rvalid;
    assign o_busy        = busy;
    assign o_done        = done;
    assign o_flags       = flags;
    assign o_result      = result;
endmodule : bct_unit
`default_nettype wire

// *** pkg/bct_regs.svh ***
/*
 * constants for the bit column transpose unit: word width, column depth, index and bit number limits.
 * assumes inclusion by bare name from package and design files.
 */
`ifndef BCT_REGS_SVH
`define BCT_REGS_SVH
`define BCT_WORD_W    16
`define BCT_NUM_WORDS 16
`define BCT_IDX_W     4
`define BCT_BITNUM_MAX 16'h000f
`define BCT_ZERO_WORD 16'h0000
`define BCT_ZERO_IDX  4'h0
`define BCT_LAST_IDX  4'hf
`endif

// *** pkg/bct_pkg.sv ***
/*
 * types shared by the bit column transpose unit.
 * assumes bct_regs.svh is on the include path.
 */
`include "bct_regs.svh"
package bct_pkg;
    typedef enum logic [1:0] {
        BCT_OP_GATHER  = 2'h1,
        BCT_OP_SCATTER = 2'h2
    } bct_op_t;

    typedef struct packed {
        bct_op_t                 op;
        logic [`BCT_WORD_W-1:0]  bit_num;
        logic [`BCT_WORD_W-1:0]  src_word;
    } bct_req_t;

    typedef struct packed {
        logic fault_flag;
        logic zero_flag;
    } bct_flags_t;
endpackage : bct_pkg

// *** logic/bct_word_mem.sv ***
/*
 * sixteen-word column memory with registered read data.
 * assumes one clock; write and read in same cycle returns old data.
 */
`timescale 1ns/1ps
`default_nettype none
`include "bct_regs.svh"
module bct_word_mem #(
    parameter int WIDTH = `BCT_WORD_W,
    parameter int DEPTH = `BCT_NUM_WORDS,
    parameter int AW    = `BCT_IDX_W
) (
    input  wire logic             i_ref_clk,
    input  wire logic             i_we,
    input  wire logic [AW-1:0]    i_waddr,
    input  wire logic [WIDTH-1:0] i_wdata,
    input  wire logic [AW-1:0]    i_raddr,
    output logic      [WIDTH-1:0] o_rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge i_ref_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule : bct_word_mem
`default_nettype wire

// *** tb/bct_unit_properties.sv ***
/* port checker for bct_unit.
   assumes it is bound into bct_unit and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module bct_unit_properties
    import bct_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input wire logic             i_ref_clk,
    input wire logic             i_rstn,
    input wire logic             i_start,
    input wire bct_req_t         i_req,
    input wire logic             i_rd,
    input wire logic             o_word_rvalid,
    input wire logic             o_busy,
    input wire logic             o_done,
    input wire bct_flags_t       o_flags,
    input wire logic [WIDTH-1:0] o_result
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    logic go;
    logic ok;
    bct_op_t op;
    logic [WIDTH-1:0] src;
    // done cycle excluded, though the unit is back in ST_IDLE there and takes a start
    assign go = i_start && !o_busy && !o_done;
    assign ok = i_req.bit_num <= 16'h000f;
    always_ff @(posedge i_ref_clk) begin
        if (go) begin
            op  <= i_req.op;
            src <= i_req.src_word;
        end
    end
    sequence s_bad; go && !ok; endsequence
    sequence s_good; go && ok; endsequence
    property p_fault; s_bad |-> ##2 o_done && o_flags.fault_flag; endproperty
    property p_good; s_good |-> ##34 o_done && !o_flags.fault_flag; endproperty
    property p_keep; s_bad |=> $stable(o_result)[*2]; endproperty
    property p_gzero;
        o_done && op == BCT_OP_GATHER && !o_flags.fault_flag |-> o_flags.zero_flag == (o_result == 16'h0000);
    endproperty
    property p_szero;
        o_done && op == BCT_OP_SCATTER && !o_flags.fault_flag |-> o_flags.zero_flag == (src == 16'h0000);
    endproperty
    property p_busy; s_good |=> o_busy[*8]; endproperty
    property p_pulse; o_done |=> !o_done; endproperty
    property p_rvalid; i_rd && !o_busy && !o_done && !i_start |-> ##2 o_word_rvalid; endproperty
    a_fault: assert property (p_fault) else $error("fault op did not end flagged");
    a_good: assert property (p_good) else $error("valid op end wrong");
    a_keep: assert property (p_keep) else $error("result moved on fault");
    a_gzero: assert property (p_gzero) else $error("gather zero flag wrong");
    a_szero: assert property (p_szero) else $error("scatter zero flag wrong");
    a_busy: assert property (p_busy) else $error("busy dropped early");
    a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
    a_rvalid: assert property (p_rvalid) else $error("read valid late");
endmodule : bct_unit_properties
bind bct_unit bct_unit_properties #(.WIDTH(WIDTH)) u_chk (.i_ref_clk, .i_rstn, .i_start, .i_req,
    .i_rd, .o_word_rvalid, .o_busy, .o_done, .o_flags, .o_result);
`default_nettype wire

// *** tb/bct_seq_model.sv ***
/* sequencer side of the word port: writes and reads data words.
   assumes one clock; requests change at the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module bct_seq_model (
    input wire logic        i_ref_clk,
    input wire logic        i_rvalid,
    input wire logic [15:0] i_rdata,
    output logic            o_wr,
    output logic            o_rd,
    output logic [3:0]      o_idx,
    output logic [15:0]     o_wdata
);
    initial begin
        o_wr = 0; o_rd = 0; o_idx = 4'h0; o_wdata = 16'h0000;
    end
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(negedge i_ref_clk);
        o_wr = 1; o_idx = a; o_wdata = d;
        @(negedge i_ref_clk);
        o_wr = 0; o_wdata = ~d; // released data must not look valid
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] q, output logic late);
        int k;
        @(negedge i_ref_clk);
        o_rd = 1; o_idx = a;
        @(negedge i_ref_clk);
        o_rd = 0; late = 1; q = 16'h0000;
        for (k = 0; k < 4 && late; k++) begin
            if (i_rvalid === 1'b1) begin q = i_rdata; late = 0; end
            else @(negedge i_ref_clk);
        end
    endtask : rd
endmodule : bct_seq_model
`default_nettype wire

// *** tb/bct_unit_bench.sv ***
/* self-checking bench for bct_unit.
   assumes the checker is bound and the sequencer model drives the word port. */
`timescale 1ns/1ps
`default_nettype none
module bct_unit_bench
    import bct_pkg::*;
;
    logic clk = 0, rstn = 0, start = 0, wr, rd, rv, late;
    bct_req_t req = '0;
    logic [3:0] idx;
    logic [15:0] wd, rdat, res, q, e, sh[16];
    bct_flags_t fl;
    int n_mismatch = 0, comparisons = 0;
    always #4 clk = ~clk;
    bct_unit dut (.i_ref_clk(clk), .i_rstn(rstn), .i_start(start), .i_req(req), .i_wr(wr),
        .i_rd(rd), .i_word_idx(idx), .i_word_wdata(wd), .o_word_rdata(rdat), .o_word_rvalid(rv),
        .o_busy(), .o_done(), .o_flags(fl), .o_result(res));
    bct_seq_model m (.i_ref_clk(clk), .i_rvalid(rv), .i_rdata(rdat), .o_wr(wr), .o_rd(rd),
        .o_idx(idx), .o_wdata(wd));
    task automatic results;
        if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results
    task automatic chk(input logic [15:0] s, input logic [15:0] x);
        comparisons++;
        if (s !== x) begin
            n_mismatch++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, s, x);
        end
    endtask : chk
    task automatic run(input bct_op_t o, input logic [15:0] n, input logic [15:0] s);
        int k;
        @(negedge clk);
        start = 1; req = '{o, n, s};
        @(negedge clk);
        start = 0;
        for (k = 0; k < 40 && dut.o_done !== 1'b1; k++) @(negedge clk);
        if (k == 40) begin n_mismatch++; results; end
        @(negedge clk);
    endtask : run
    task automatic load(input logic [15:0] b, input logic [15:0] st);
        for (int i = 0; i < 16; i++) begin sh[i] = b ^ (st * i); m.wr(i, sh[i]); end
    endtask : load
    task automatic verify;
        for (int i = 0; i < 16; i++) begin
            m.rd(i, q, late);
            if (late) begin n_mismatch++; results; end
            chk(q, sh[i]);
        end
    endtask : verify
    task automatic gat(input logic [15:0] n);
        for (int i = 0; i < 16; i++) e[i] = sh[i][n];
        run(BCT_OP_GATHER, n, 16'h0000);
        chk(res, e);
        chk({15'h0000, fl.zero_flag}, {15'h0000, e == 16'h0000});
        chk({15'h0000, fl.fault_flag}, 16'h0000);
    endtask : gat
    task automatic sct(input logic [15:0] n, input logic [15:0] s);
        for (int i = 0; i < 16; i++) sh[i][n] = s[i];
        run(BCT_OP_SCATTER, n, s);
        chk({15'h0000, fl.zero_flag}, {15'h0000, s == 16'h0000});
        verify;
    endtask : sct
    task automatic scn_gather;
        load(16'ha5c3, 16'h0111);
        gat(16'h0005);
        gat(16'h000f);
        load(16'h7fff, 16'h0000);
        gat(16'h000f);
        gat(16'h0000);
    endtask : scn_gather
    task automatic scn_scatter;
        load(16'h3c96, 16'h0203);
        sct(16'h0000, 16'h8001);
        sct(16'h000f, 16'h0000);
        sct(16'h0007, 16'hffff);
    endtask : scn_scatter
    task automatic scn_fault;
        logic [15:0] r;
        for (int k = 0; k < 4; k++) begin
            r = res;
            run(k[0] ? BCT_OP_SCATTER : BCT_OP_GATHER, k[1] ? 16'hffff : 16'h0010, 16'h5a5a);
            chk({15'h0000, fl.fault_flag}, 16'h0001);
            chk(res, r);
            verify;
        end
        gat(16'h0003);
    endtask : scn_fault
    initial begin
        repeat (20) @(negedge clk);
        rstn = 1;
        scn_gather;
        scn_scatter;
        scn_fault;
        results;
    end
endmodule : bct_unit_bench
`default_nettype wire
